// ### hw/mcs_main_clock.sv
`timescale 1ns/100ps
// main clock select, prescale, protection and sleep gating
module mcs_main_clock (
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire logic [5:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    input  wire logic [3:0]          src_clk_en,
    input  wire logic [3:0]          src_ready,
    input  wire logic [3:0]          periph_request,
    input  wire logic [1:0]          sleep_mode,
    input  wire logic                nvm_busy,
    input  wire logic                failure_override,
    output logic [3:0]               osc_run,
    output logic                     main_clk_en,
    output logic                     periph_clock_en,
    output logic                     pin_clock_out,
    output logic                     pin_clock_oe,
    output logic                     failure_watch_en
);
    // configuration registers
    logic [7:0] sel_r, presc_r, failcfg_r, irqctl_r, irqflg_r;
    logic [7:0] fosc_r, ftrim_r, pll_r, sosc_r, sxtal_r, fext_r;
    // unlock window counter
    logic [2:0] unlock_cnt_r;
    // failure suppression counter after reset
    logic [11:0] sut_cnt_r;
    // prescaler counter and applied ratio
    logic [5:0] div_cnt_r;
    logic [5:0] div_cur_r;
    logic       presc_on_r;
    // committed source for glitch-free change
    logic [3:0] src_cur_r;
    // output flops
    logic [3:0] osc_run_r;
    logic       main_en_r, per_en_r, pin_r, oe_r, watch_r;
    logic [7:0] rdata_r;

    // decode
    wire        wr_hit       = reg_wr;
    wire        unlocked     = (unlock_cnt_r != 3'h0);
    wire        key_write    = wr_hit && reg_addr == mcs_pkg::MCS_UNLOCK_OFS
                               && reg_wdata == mcs_pkg::MCS_IO_KEY;
    wire        prot_wr      = wr_hit && unlocked;
    wire        wr_sel       = prot_wr && reg_addr == mcs_pkg::MCS_SELECT_OFS;
    wire        wr_presc     = prot_wr && reg_addr == mcs_pkg::MCS_PRESCALE_OFS;
    wire        wr_failcfg   = prot_wr && reg_addr == mcs_pkg::MCS_FAILCFG_OFS;
    wire        wr_irqctl    = prot_wr && reg_addr == mcs_pkg::MCS_IRQCTL_OFS;
    wire        wr_fosc      = prot_wr && reg_addr == mcs_pkg::MCS_FOSC_OFS;
    wire        wr_pll       = prot_wr && reg_addr == mcs_pkg::MCS_PLL_OFS;
    wire        wr_sosc      = prot_wr && reg_addr == mcs_pkg::MCS_SOSC_OFS;
    wire        wr_sxtal     = prot_wr && reg_addr == mcs_pkg::MCS_SXTAL_OFS;
    wire        wr_fext      = prot_wr && reg_addr == mcs_pkg::MCS_FEXT_OFS;
    // trim and flags are unprotected
    wire        wr_ftrim     = wr_hit && reg_addr == mcs_pkg::MCS_FTRIM_OFS;
    wire        wr_flags     = wr_hit && reg_addr == mcs_pkg::MCS_IRQFLG_OFS;

    // failure handling
    wire        sut_done     = (sut_cnt_r == 12'h000);
    wire        fail_evt     = failure_override && sut_done && watch_r;
    wire        main_monitored = (failcfg_r[3:2] == 2'h0);
    wire        main_fail    = fail_evt && main_monitored;

    // run-in-standby per source, indexed by source code
    wire [3:0]  run_sb       = {fext_r[mcs_pkg::MCS_RUN_SB_BIT],
                                sxtal_r[mcs_pkg::MCS_RUN_SB_BIT],
                                sosc_r[mcs_pkg::MCS_RUN_SB_BIT],
                                fosc_r[mcs_pkg::MCS_RUN_SB_BIT]};
    wire        src_valid    = (sel_r[3:0] <= mcs_pkg::MCS_SRC_EXT);
    wire [1:0]  src_idx      = src_valid ? sel_r[1:0] : 2'h0;
    wire        sel_runsb    = run_sb[src_idx];
    wire        any_req      = |periph_request;
    wire        pd_mode      = (sleep_mode == mcs_pkg::MCS_POWERDOWN);

    // main clock need per sleep mode
    logic main_need;
    always_comb begin
        unique case (mcs_pkg::mcs_sleep_t'(sleep_mode))
            mcs_pkg::MCS_ACTIVE,
            mcs_pkg::MCS_IDLE:      main_need = 1'b1;
            mcs_pkg::MCS_STANDBY:   main_need = any_req || sel_runsb;
            mcs_pkg::MCS_POWERDOWN: main_need = nvm_busy;
        endcase
    end

    // per oscillator run decision
    logic [3:0] osc_need;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            // used as main source, requested, or held by run-in-standby
            osc_need[i] = (main_need && src_idx == 2'(i))
                          || periph_request[i]
                          || (run_sb[i] && !pd_mode);
        end
    end

    // division decode
    logic [5:0] div_sel;
    always_comb begin
        unique case (presc_r[4:1])
            4'h0:    div_sel = 6'h02;
            4'h1:    div_sel = 6'h04;
            4'h2:    div_sel = 6'h08;
            4'h3:    div_sel = 6'h10;
            4'h4:    div_sel = 6'h20;
            4'h5:    div_sel = 6'h3f;
            4'h8:    div_sel = 6'h06;
            4'h9:    div_sel = 6'h0a;
            4'ha:    div_sel = 6'h0c;
            4'hb:    div_sel = 6'h18;
            4'hc:    div_sel = 6'h30;
            default: div_sel = 6'h02;
        endcase
    end
    // divide by 64 needs seven bits; count to 63 then one extra tick
    logic [6:0] div_full_cur;   // applied period length
    logic       div64_r;        // applied ratio is the widest one
    assign div_full_cur = div64_r ? 7'h40 : {1'b0, div_cur_r};
    wire        div_wrap     = ({1'b0, div_cnt_r} + 7'h01 >= div_full_cur);
    // periph tick: undivided when prescaler off
    wire        per_tick     = presc_on_r ? div_wrap : 1'b1;
    // source ready for use: run-in-standby skips start-up wait
    wire        src_ok       = src_ready[src_idx] || run_sb[src_idx];

    // unlock window
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unlock_cnt_r <= 3'h0;
        end else if (key_write) begin
            unlock_cnt_r <= mcs_pkg::MCS_UNLOCK_CYC;
        end else if (prot_wr || unlocked) begin
            // one protected write closes it, else it counts down
            unlock_cnt_r <= prot_wr ? 3'h0 : unlock_cnt_r - 3'h1;
        end
    end

    // select register: pin bit and source field
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_r <= mcs_pkg::MCS_REG_RESET;
        end else if (main_fail) begin
            // failure beats a same-cycle write
            sel_r <= {1'b0, sel_r[6:4], mcs_pkg::MCS_SRC_FAST};
        end else if (wr_sel) begin
            sel_r <= reg_wdata & mcs_pkg::MCS_SELECT_MASK;
        end
    end

    // remaining configuration registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            presc_r   <= mcs_pkg::MCS_REG_RESET;
            failcfg_r <= mcs_pkg::MCS_REG_RESET;
            irqctl_r  <= mcs_pkg::MCS_REG_RESET;
            fosc_r    <= mcs_pkg::MCS_REG_RESET;
            ftrim_r   <= mcs_pkg::MCS_REG_RESET;
            pll_r     <= mcs_pkg::MCS_REG_RESET;
            sosc_r    <= mcs_pkg::MCS_REG_RESET;
            sxtal_r   <= mcs_pkg::MCS_REG_RESET;
            fext_r    <= mcs_pkg::MCS_REG_RESET;
        end else begin
            if (wr_presc)   presc_r   <= reg_wdata & mcs_pkg::MCS_PRESC_MASK;
            if (wr_failcfg) failcfg_r <= reg_wdata & mcs_pkg::MCS_FAILCFG_MASK;
            if (wr_irqctl)  irqctl_r  <= reg_wdata & mcs_pkg::MCS_IRQCTL_MASK;
            if (wr_fosc)    fosc_r    <= reg_wdata & mcs_pkg::MCS_FOSC_MASK;
            if (wr_ftrim)   ftrim_r   <= reg_wdata;
            if (wr_pll)     pll_r     <= reg_wdata & mcs_pkg::MCS_PLL_MASK;
            if (wr_sosc)    sosc_r    <= reg_wdata & mcs_pkg::MCS_SOSC_MASK;
            if (wr_sxtal)   sxtal_r   <= reg_wdata & mcs_pkg::MCS_SXTAL_MASK;
            if (wr_fext)    fext_r    <= reg_wdata & mcs_pkg::MCS_FEXT_MASK;
        end
    end

    // failure flag: set wins over write-one clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irqflg_r <= mcs_pkg::MCS_REG_RESET;
        end else if (fail_evt) begin
            irqflg_r <= 8'h01;
        end else if (wr_flags && reg_wdata[0]) begin
            irqflg_r <= 8'h00;
        end
    end

    // start-up suppression after reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sut_cnt_r <= mcs_pkg::MCS_STARTUP_CYC;
        end else if (!sut_done) begin
            sut_cnt_r <= sut_cnt_r - 12'h001;
        end
    end

    // committed source and ratio change only at a divider wrap or while the prescaler is off
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            src_cur_r  <= mcs_pkg::MCS_SRC_FAST;
            div_cur_r  <= 6'h02;
            div64_r    <= 1'b0;
            presc_on_r <= 1'b0;
            div_cnt_r  <= 6'h00;
        end else begin
            if (!presc_on_r || div_wrap) begin
                // safe edge: period boundary, no runt period
                div_cnt_r  <= 6'h00;
                div_cur_r  <= div_sel;
                div64_r    <= (presc_r[4:1] == 4'h5);
                presc_on_r <= presc_r[0];
                if (src_ok) src_cur_r <= {2'h0, src_idx};
            end else begin
                div_cnt_r  <= div_cnt_r + 6'h01;
            end
        end
    end

    // outputs
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            osc_run_r <= 4'h1;
            main_en_r <= 1'b1;
            per_en_r  <= 1'b0;
            pin_r     <= 1'b0;
            oe_r      <= 1'b0;
            watch_r   <= 1'b0;
        end else begin
            osc_run_r <= osc_need;
            main_en_r <= main_need && src_ok;
            per_en_r  <= main_need && src_ok && per_tick;
            pin_r     <= main_need && sel_r[mcs_pkg::MCS_PIN_OUT_BIT];
            oe_r      <= sel_r[mcs_pkg::MCS_PIN_OUT_BIT];
            // watch only while enabled and, in sleep, source is running
            watch_r   <= failcfg_r[0] && (sleep_mode == 2'h0
                         || src_clk_en[main_monitored ? src_idx
                                       : (failcfg_r[3:2] == 2'h1 ? 2'h3 : 2'h2)]);
        end
    end

    // read mux, gaps read zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            mcs_pkg::MCS_SELECT_OFS:   rd_mux = sel_r;
            mcs_pkg::MCS_PRESCALE_OFS: rd_mux = presc_r;
            mcs_pkg::MCS_FAILCFG_OFS:  rd_mux = failcfg_r;
            mcs_pkg::MCS_IRQCTL_OFS:   rd_mux = irqctl_r;
            mcs_pkg::MCS_IRQFLG_OFS:   rd_mux = irqflg_r;
            mcs_pkg::MCS_STATUS_OFS:   rd_mux = {4'h0, src_ready};
            mcs_pkg::MCS_FOSC_OFS:     rd_mux = fosc_r;
            mcs_pkg::MCS_FTRIM_OFS:    rd_mux = ftrim_r;
            mcs_pkg::MCS_PLL_OFS:      rd_mux = pll_r;
            mcs_pkg::MCS_SOSC_OFS:     rd_mux = sosc_r;
            mcs_pkg::MCS_SXTAL_OFS:    rd_mux = sxtal_r;
            mcs_pkg::MCS_FEXT_OFS:     rd_mux = fext_r;
            default:                   rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata        = rdata_r;
    assign osc_run          = osc_run_r;
    assign main_clk_en      = main_en_r;
    assign periph_clock_en  = per_en_r;
    assign pin_clock_out    = pin_r;
    assign pin_clock_oe     = oe_r;
    assign failure_watch_en = watch_r;
endmodule : mcs_main_clock

// ### hw/mcs_pkg.sv
// Contract
// - stop sources neither used nor requested
// - run-in-standby keeps oscillator on except power-down
// - run-in-standby oscillator serves requests without start-up
// - main clock always runs in active and idle; code stops it while selected source is neither ready nor run-in-standby
// - standby: main clock only if requested or run-in-standby
// - power-down: stop after nonvolatile operations finish
// - sleep: failure monitoring only while source active
// - suppress failure detection for start-up time
// - protected writes without open unlock ignored
// - protect select, prescale, fail config, irq, oscillators; code leaves trim and irq flag registers writable without unlock
// - pin output bit drives main clock out
// - pin bit set/cleared by write, cleared on failure
// - four-bit source select, other codes reserved
// - division ratio applies only when prescaler on
// - division code decode table
// - select and prescale reset to zero
// - prescaler off passes clock undivided
// - failure forces start-up source
package mcs_pkg;
    // register offsets
    localparam logic [5:0] MCS_SELECT_OFS   = 6'h00;
    localparam logic [5:0] MCS_PRESCALE_OFS = 6'h01;
    localparam logic [5:0] MCS_FAILCFG_OFS  = 6'h02;
    localparam logic [5:0] MCS_IRQCTL_OFS   = 6'h03;
    localparam logic [5:0] MCS_IRQFLG_OFS   = 6'h04;
    localparam logic [5:0] MCS_STATUS_OFS   = 6'h05;
    localparam logic [5:0] MCS_FOSC_OFS     = 6'h08;
    localparam logic [5:0] MCS_FTRIM_OFS    = 6'h09;
    localparam logic [5:0] MCS_PLL_OFS      = 6'h10;
    localparam logic [5:0] MCS_SOSC_OFS     = 6'h18;
    localparam logic [5:0] MCS_SXTAL_OFS    = 6'h1c;
    localparam logic [5:0] MCS_FEXT_OFS     = 6'h20;
    localparam logic [5:0] MCS_UNLOCK_OFS   = 6'h30;
    // field positions and writable masks
    localparam int         MCS_PIN_OUT_BIT  = 7;
    localparam int         MCS_RUN_SB_BIT   = 7;
    localparam logic [7:0] MCS_SELECT_MASK  = 8'h8f;
    localparam logic [7:0] MCS_PRESC_MASK   = 8'h1f;
    localparam logic [7:0] MCS_FAILCFG_MASK = 8'h0f;
    localparam logic [7:0] MCS_IRQCTL_MASK  = 8'h81;
    localparam logic [7:0] MCS_PLL_MASK     = 8'hc3;
    localparam logic [7:0] MCS_SOSC_MASK    = 8'h80;
    localparam logic [7:0] MCS_SXTAL_MASK   = 8'hb7;
    localparam logic [7:0] MCS_FEXT_MASK    = 8'hbf;
    localparam logic [7:0] MCS_FOSC_MASK    = 8'hbd;
    // reset values
    localparam logic [7:0] MCS_REG_RESET    = 8'h00;
    // unlock key and window
    localparam logic [7:0] MCS_IO_KEY       = 8'hd8;
    localparam logic [2:0] MCS_UNLOCK_CYC   = 3'h4;
    // source codes
    localparam logic [3:0] MCS_SRC_FAST     = 4'h0;
    localparam logic [3:0] MCS_SRC_SLOW     = 4'h1;
    localparam logic [3:0] MCS_SRC_XTAL     = 4'h2;
    localparam logic [3:0] MCS_SRC_EXT      = 4'h3;
    // start-up time of monitored oscillator
    localparam int         MCS_STARTUP_NS   = 8000;
    localparam int         MCS_CLK_NS       = 8;
    localparam logic [11:0] MCS_STARTUP_CYC = 12'((MCS_STARTUP_NS + MCS_CLK_NS - 1) / MCS_CLK_NS);
    // sleep modes
    typedef enum logic [1:0] {
        MCS_ACTIVE, MCS_IDLE, MCS_STANDBY, MCS_POWERDOWN
    } mcs_sleep_t;
endpackage : mcs_pkg

// ### testbench/mcs_main_clock_asserts.sv
`timescale 1ns/100ps
// port-level checks for the main clock block
module mcs_main_clock_asserts (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] src_clk_en,
    input wire logic [3:0] src_ready,
    input wire logic [3:0] periph_request,
    input wire logic [1:0] sleep_mode,
    input wire logic       nvm_busy,
    input wire logic       failure_override,
    input wire logic [3:0] osc_run,
    input wire logic       main_clk_en,
    input wire logic       periph_clock_en,
    input wire logic       pin_clock_out,
    input wire logic       pin_clock_oe,
    input wire logic       failure_watch_en
);
    localparam int HOLD_CYC = 990;  // kept under the holdoff so edge slack never fires
    logic [11:0] since_rst_r;       // cycles since reset, saturating
    // count from reset release; saturate so it never wraps back into holdoff
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            since_rst_r <= 12'h000;
        else if (since_rst_r != 12'hfff)
            since_rst_r <= since_rst_r + 12'h001;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence s_awake; sleep_mode < 2'h2; endsequence
    sequence s_pd_busy; (sleep_mode == 2'h3 && nvm_busy) [*2]; endsequence
    chk_awake_main_runs: assert property (s_awake [*3] |-> main_clk_en)
        else $error("main clock stopped while awake");
    chk_pd_hold_nvm: assert property (s_awake ##1 s_pd_busy |-> main_clk_en)
        else $error("main clock stopped with nvm busy");
    chk_pd_stop_main: assert property ((sleep_mode == 2'h3 && !nvm_busy) [*3] |-> !main_clk_en)
        else $error("main clock running in power-down");
    chk_pd_osc_off: assert property ((sleep_mode == 2'h3 && !nvm_busy && periph_request == 4'h0) [*4]
        |-> osc_run == 4'h0)
        else $error("oscillator running in power-down");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_gap_reads_zero: assert property (reg_rd && reg_addr == 6'h06 |=> reg_rdata == 8'h00)
        else $error("reserved gap read nonzero");
    chk_pin_needs_bit: assert property (pin_clock_out |-> pin_clock_oe)
        else $error("clock pin driven without enable");
    chk_holdoff_ignored: assert property (since_rst_r < HOLD_CYC && failure_override && !reg_wr
        |=> !$fell(pin_clock_oe))
        else $error("failure acted on during holdoff");
    chk_fail_clears_pin: assert property (since_rst_r > 12'd1010 && failure_override && pin_clock_oe
        |-> ##[1:4] !pin_clock_oe)
        else $error("failure did not clear clock pin");
    chk_reset_undivided: assert property ($rose(reset_n) |-> ##2 periph_clock_en [*4])
        else $error("peripheral enable not constant after reset");
endmodule : mcs_main_clock_asserts

bind mcs_main_clock mcs_main_clock_asserts u_chk (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_clk_en(src_clk_en),
    .src_ready(src_ready), .periph_request(periph_request), .sleep_mode(sleep_mode),
    .nvm_busy(nvm_busy), .failure_override(failure_override), .osc_run(osc_run),
    .main_clk_en(main_clk_en), .periph_clock_en(periph_clock_en),
    .pin_clock_out(pin_clock_out), .pin_clock_oe(pin_clock_oe),
    .failure_watch_en(failure_watch_en));

// ### testbench/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
// register-level bench for the main clock block
module testbench;
    logic       mclk, reset_n, reg_wr, reg_rd, nvm_busy, failure_override;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic [3:0] src_clk_en, src_ready, periph_request, osc_run;
    logic [1:0] sleep_mode;
    logic       main_clk_en, periph_clock_en, pin_clock_out, pin_clock_oe, failure_watch_en;
    int         bad_count, tests_run, cycles, gap_n;
    // protected registers and their writable bits
    localparam logic [5:0] OFS [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h10, 6'h18, 6'h1c, 6'h20};
    localparam logic [7:0] MSK [9] = '{8'h8f, 8'h1f, 8'h0f, 8'h81, 8'hbd, 8'hc3, 8'h80, 8'hb7, 8'hbf};
    // division codes and the periods they give
    localparam logic [3:0] DCODE [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha,
                                         4'hb, 4'hc};
    localparam int         DIVS [11]  = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
    mcs_main_clock dut (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_clk_en(src_clk_en),
        .src_ready(src_ready), .periph_request(periph_request), .sleep_mode(sleep_mode),
        .nvm_busy(nvm_busy), .failure_override(failure_override), .osc_run(osc_run),
        .main_clk_en(main_clk_en), .periph_clock_en(periph_clock_en),
        .pin_clock_out(pin_clock_out), .pin_clock_oe(pin_clock_oe),
        .failure_watch_en(failure_watch_en));
    // 125 MHz
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    // cut a hang short well past the expected run
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            summarize();
        end
    end
    // one write, optionally preceded by the unlock key on the next-to-last edge
    task automatic put(input logic [5:0] a, input logic [7:0] d, input bit key);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= key ? mcs_pkg::MCS_UNLOCK_OFS : a;
        reg_wdata <= key ? mcs_pkg::MCS_IO_KEY : d;
        if (key) begin
            @(posedge mclk);
            reg_addr <= a;
            reg_wdata <= d;
        end
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : put
    // read and compare; data stands only in the cycle after the strobe
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd_val = reg_rdata;
        `CHK("reg_rdata", e, rd_val)
    endtask : rdc
    // let n edges land, then look mid-cycle
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : hold
    // cycles from one enable pulse to the next, bounded
    task automatic gap(output int n);
        for (int k = 0; k < 200 && periph_clock_en !== 1'b1; k++) @(negedge mclk);
        n = 1;
        @(negedge mclk);
        while (periph_clock_en !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
    endtask : gap
    // drive the sleep, nvm busy and request levels at a rising edge
    task automatic lvl(input logic [1:0] s, input logic nb, input logic [3:0] rq);
        @(posedge mclk);
        sleep_mode <= s;
        nvm_busy <= nb;
        periph_request <= rq;
    endtask : lvl
    initial begin
        {reg_wr, reg_rd, nvm_busy, failure_override, reset_n} = '0;
        {reg_addr, reg_wdata, periph_request, sleep_mode} = '0;
        src_clk_en = 4'hf;
        src_ready = 4'hf;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rdc(mcs_pkg::MCS_SELECT_OFS, 8'h00);
        rdc(mcs_pkg::MCS_PRESCALE_OFS, 8'h00);
        rdc(6'h06, 8'h00);
        `CHK("osc_run", 4'h1, osc_run)
        $display("reset values done");
        put(mcs_pkg::MCS_SELECT_OFS, 8'h81, 1'b0);
        rdc(mcs_pkg::MCS_SELECT_OFS, 8'h00);
        put(mcs_pkg::MCS_SELECT_OFS, 8'h81, 1'b1);
        rdc(mcs_pkg::MCS_SELECT_OFS, 8'h81);
        `CHK("pin_clock_oe", 1'b1, pin_clock_oe)
        `CHK("pin_clock_out", 1'b1, pin_clock_out)
        put(mcs_pkg::MCS_UNLOCK_OFS, mcs_pkg::MCS_IO_KEY, 1'b0);
        hold(6);
        put(mcs_pkg::MCS_PRESCALE_OFS, 8'h03, 1'b0);
        rdc(mcs_pkg::MCS_PRESCALE_OFS, 8'h00);
        put(mcs_pkg::MCS_FAILCFG_OFS, 8'h01, 1'b1);
        @(posedge mclk);
        failure_override <= 1'b1;
        hold(4);
        `CHK("pin_clock_oe", 1'b1, pin_clock_oe)
        @(posedge mclk);
        failure_override <= 1'b0;
        rdc(mcs_pkg::MCS_SELECT_OFS, 8'h81);
        $display("protection and holdoff done");
        for (int i = 0; i < 11; i++) begin
            put(mcs_pkg::MCS_PRESCALE_OFS, {3'h0, DCODE[i], 1'b1}, 1'b1);
            repeat (3) gap(gap_n);
            `CHK("enable period", DIVS[i], gap_n)
        end
        put(mcs_pkg::MCS_PRESCALE_OFS, 8'h00, 1'b1);
        repeat (3) gap(gap_n);
        `CHK("enable period", 1, gap_n)
        $display("prescaler done");
        // let the failure holdoff after reset run out first
        hold(1000);
        put(mcs_pkg::MCS_SELECT_OFS, 8'h83, 1'b1);
        @(posedge mclk);
        failure_override <= 1'b1;
        hold(4);
        `CHK("pin_clock_oe", 1'b0, pin_clock_oe)
        rdc(mcs_pkg::MCS_SELECT_OFS, 8'h00);
        @(posedge mclk);
        failure_override <= 1'b0;
        rdc(mcs_pkg::MCS_IRQFLG_OFS, 8'h01);
        put(mcs_pkg::MCS_IRQFLG_OFS, 8'h01, 1'b0);
        rdc(mcs_pkg::MCS_IRQFLG_OFS, 8'h00);
        $display("failure done");
        lvl(mcs_pkg::MCS_IDLE, 1'b0, 4'h0);
        hold(3);
        `CHK("main_clk_en", 1'b1, main_clk_en)
        lvl(mcs_pkg::MCS_STANDBY, 1'b0, 4'h0);
        src_clk_en <= 4'he;
        hold(4);
        `CHK("main_clk_en", 1'b0, main_clk_en)
        `CHK("failure_watch_en", 1'b0, failure_watch_en)
        lvl(mcs_pkg::MCS_STANDBY, 1'b0, 4'h1);
        src_clk_en <= 4'hf;
        hold(4);
        `CHK("main_clk_en", 1'b1, main_clk_en)
        `CHK("failure_watch_en", 1'b1, failure_watch_en)
        `CHK("osc_run", 4'h1, osc_run)
        lvl(mcs_pkg::MCS_ACTIVE, 1'b0, 4'h0);
        put(mcs_pkg::MCS_FOSC_OFS, 8'h80, 1'b1);
        lvl(mcs_pkg::MCS_STANDBY, 1'b0, 4'h0);
        hold(4);
        `CHK("main_clk_en", 1'b1, main_clk_en)
        lvl(mcs_pkg::MCS_ACTIVE, 1'b0, 4'h0);
        hold(3);
        lvl(mcs_pkg::MCS_POWERDOWN, 1'b1, 4'h0);
        hold(4);
        `CHK("main_clk_en", 1'b1, main_clk_en)
        lvl(mcs_pkg::MCS_POWERDOWN, 1'b0, 4'h0);
        hold(5);
        `CHK("main_clk_en", 1'b0, main_clk_en)
        `CHK("osc_run", 4'h0, osc_run)
        lvl(mcs_pkg::MCS_ACTIVE, 1'b0, 4'h0);
        hold(4);
        $display("sleep done");
        for (int i = 0; i < 9; i++) begin
            put(OFS[i], 8'hfd, 1'b1);
            rdc(OFS[i], MSK[i] & 8'hfd);
            put(OFS[i], 8'h00, 1'b0);
            rdc(OFS[i], MSK[i] & 8'hfd);
        end
        $display("register table done");
        summarize();
    end
endmodule : testbench
